// ### rtl/dcl_link.v
// Summary of operation
// R1: words are start low, eight data bits lsb first, stop high; idle high.
// R2: each operation opens with 55h; its timing sets the baud rate.
// R3: command byte holds global, read, command flags then 5-bit field.
// R4: global operations name the highest address, individual ones the exact one.
// R5: a non-responding device repeats traffic both ways between its pins.
// R6: device address lives in nonvolatile storage and reloads on reset.
// R7: host follows address-init with one word carrying the first address.
// R8: devices self-assign in sequence, each answering upward after 7 ms.
// R9: host sends nothing new until address init completes.
// R10: a stalled address init drops back to idle after one second.
// R11: last-device poll is answered by the last device with its address.
// R12: only the device that was last at init answers the poll.
// R13: global reset reloads stored values and clears temperature, like config bit 1.
// R14: individual write changes only the device whose address matches.
// R15: individual read reply starts within 1.5 baud periods.
// R16: global write stores in every device up to the named address.
// R17: global read returns named device first, ending at the first device.
// R18: global read past the last device gives up after 35 ms.
// R19: global read replies start within 1.5 baud periods.
// R20: continuous conversion is default; results update temperature and alert flags.
// R21: shutdown stops conversions but leaves every register reachable.
// R22: one-shot bit starts one conversion in shutdown and reads zero.
// R23: storage holds eight general words at pointers 6h to Dh.
// R24: reset copies stored values into registers, not temperature or die id.
// R25: storage is locked at power-up; locked writes to it are ignored.
// R26: host unlocks storage by writing 1 to temperature bit 0.
// R27: a non-matching device forwards unchanged, stores nothing, replies nothing.
`default_nettype none
`include "dcl_regs.vh"
module dcl_link #(
  parameter [29:0] GAP_CYC   = `DCL_GAP_MS * 1000000 / `DCL_CLK_NS,
  parameter [29:0] AINIT_CYC = `DCL_AINIT_TMO_MS * 1000000 / `DCL_CLK_NS,
  parameter [29:0] GRD_CYC   = `DCL_GRD_TMO_MS * 1000000 / `DCL_CLK_NS
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        upstream_pin_in,
  output wire        upstream_pin_out,
  output wire        upstream_pin_oe,
  input  wire        downstream_pin_in,
  output wire        downstream_pin_out,
  output wire        downstream_pin_oe,
  input  wire        conv_busy,
  input  wire        conv_done,
  input  wire [13:0] conv_result,
  input  wire [1:0]  conv_alert,
  output reg         conv_start_ff,
  output wire        shutdown_mode,
  output reg         storage_unlock_bit,
  output reg  [4:0]  device_address,
  output wire        last_device
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] S_CAL   = 4'h0;
  localparam [3:0] S_CMD   = 4'h1;
  localparam [3:0] S_PTR   = 4'h2;
  localparam [3:0] S_DLO   = 4'h3;
  localparam [3:0] S_DHI   = 4'h4;
  localparam [3:0] S_FWD   = 4'h5;
  localparam [3:0] S_SEND  = 4'h6;
  localparam [3:0] S_AINIT = 4'h7;
  localparam [3:0] S_AGAP  = 4'h8;
  localparam [3:0] S_ANEXT = 4'h9;
  localparam [3:0] S_AFWD  = 4'ha;

  reg  [3:0]  state_ff;
  reg  [15:0] baud_ff;
  reg  [7:0]  cmd_ff;
  reg  [3:0]  ptr_ff;
  reg  [7:0]  lo_ff;
  reg         sel_ff;
  reg         own_ff;
  reg  [5:0]  left_ff;
  reg  [29:0] tmr_ff;
  reg  [29:0] aint_ff;
  reg  [1:0]  sent_ff;
  reg         got_ff;
  reg         tx_go_ff;
  reg  [7:0]  tx_dat_ff;
  reg  [13:0] temp_ff;
  reg         load_ff;
  reg         os_pend_ff;
  reg  [15:0] reg_ff [1:13];
  reg  [15:0] nv_mem [1:13];
  reg  [4:0]  nv_addr;
  reg         nv_last;
  reg  [15:0] rd_val;
  integer     i;

  wire [7:0]  up_data;
  wire        up_valid;
  wire [15:0] cal_baud;
  wire        cal_valid;
  wire        dn_valid;
  wire        tx_line;
  wire        tx_busy;

  // ----------------------------------------
  // stored defaults
  // ----------------------------------------
  initial begin
    for (i = 1; i < 14; i = i + 1)
      nv_mem[i] = `DCL_NV_RESET;
    nv_mem[1] = `DCL_CFG_RESET;
    nv_addr   = `DCL_ADDR_RESET;
    nv_last   = 1'b0;
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire [4:0] field     = cmd_ff[7:3];
  wire       is_global = cmd_ff[`DCL_FLD_GLOBAL];
  wire       is_read   = cmd_ff[`DCL_FLD_READ];
  wire       quiet     = (state_ff == S_AINIT) | (state_ff == S_AGAP) |
                         (state_ff == S_ANEXT) | (state_ff == S_AFWD);
  wire       fwd_up    = (state_ff == S_FWD) | (state_ff == S_SEND) |
                         (state_ff == S_AGAP) | (state_ff == S_ANEXT) |
                         (state_ff == S_AFWD);
  wire       tx_dn     = state_ff == S_ANEXT;
  wire       tx_free   = !tx_busy && !tx_go_ff;
  wire       wr_en     = (state_ff == S_DHI) && up_valid && sel_ff && !is_read;
  wire [15:0] wr_data  = {up_data, lo_ff};
  wire [15:0] wr_val   = (ptr_ff == `DCL_PTR_CFG) ?
                         (wr_data & ~(16'h0001 << `DCL_CFG_ONE_SHOT) &
                          ~(16'h0001 << `DCL_CFG_SOFT_RST)) : wr_data;
  wire       ptr_live  = (ptr_ff >= `DCL_PTR_CFG) && (ptr_ff <= `DCL_PTR_LIM_HI);
  wire       ptr_nv    = (ptr_ff >= `DCL_PTR_NV_LO) && (ptr_ff <= `DCL_PTR_NV_HI);
  wire       addr_set  = (state_ff == S_AINIT) && up_valid;
  wire       last_set  = (state_ff == S_AFWD) && !got_ff && (tmr_ff >= {GAP_CYC[28:0], 1'b0});

  assign shutdown_mode = reg_ff[1][`DCL_CFG_SHUTDOWN];
  assign last_device   = nv_last;

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign upstream_pin_oe    = fwd_up; // [R5]
  assign upstream_pin_out   = (tx_busy && !tx_dn) ? tx_line : downstream_pin_in; // [R5] [R27]
  assign downstream_pin_oe  = !fwd_up || tx_dn;
  assign downstream_pin_out = tx_dn ? tx_line : (quiet | upstream_pin_in); // [R5] [R8]

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    rd_val = 16'h0000;
    if (ptr_ff == `DCL_PTR_TEMP)
      rd_val = {temp_ff, 1'b0, storage_unlock_bit};
    else if (ptr_live || ptr_nv)
      rd_val = reg_ff[ptr_ff]; // [R21] [R22] [R25]
    else if (ptr_ff == `DCL_PTR_DIE)
      rd_val = `DCL_DIE_ID;
  end

  // ----------------------------------------
  // word engines
  // ----------------------------------------
  dcl_rx u_up_rx (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .line_in      (upstream_pin_in),
    .cal_en       (state_ff == S_CAL),
    .baud_in      (baud_ff),
    .data_ff      (up_data),
    .valid_ff     (up_valid),
    .cal_baud_ff  (cal_baud),
    .cal_valid_ff (cal_valid)
  );

  dcl_rx u_dn_rx (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .line_in      (downstream_pin_in),
    .cal_en       (1'b0),
    .baud_in      (baud_ff),
    .data_ff      (),
    .valid_ff     (dn_valid),
    .cal_baud_ff  (),
    .cal_valid_ff ()
  );

  dcl_tx u_tx (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .start    (tx_go_ff),
    .data     (tx_dat_ff),
    .baud     (baud_ff),
    .line_out (tx_line),
    .busy     (tx_busy)
  );

  // ----------------------------------------
  // registers and storage
  // ----------------------------------------
  always @(posedge clock) begin
    if (load_ff) begin
      for (i = 1; i < 14; i = i + 1)
        reg_ff[i] <= nv_mem[i]; // [R24] [R13]
    end else begin
      if (wr_en && (ptr_live || (ptr_nv && storage_unlock_bit)))
        reg_ff[ptr_ff] <= wr_val; // [R14] [R16] [R21] [R25] [R23]
      if (conv_done)
        reg_ff[1][`DCL_CFG_ALERT_HI:`DCL_CFG_ALERT_LO] <= conv_alert; // [R20]
    end
    if (wr_en && storage_unlock_bit && (ptr_live || ptr_nv))
      nv_mem[ptr_ff] <= wr_val; // [R25]
    if (addr_set)
      nv_addr <= up_data[7:3]; // [R6]
    if (addr_set)
      nv_last <= 1'b0;
    else if (last_set)
      nv_last <= 1'b1; // [R12]
  end

  // ----------------------------------------
  // conversion control and status
  // ----------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      load_ff            <= 1'b1;
      temp_ff            <= 14'h0000;
      storage_unlock_bit <= 1'b0;
      os_pend_ff         <= 1'b0;
      conv_start_ff      <= 1'b0;
      device_address     <= `DCL_ADDR_RESET;
    end else begin
      load_ff       <= 1'b0;
      conv_start_ff <= 1'b0;
      if (load_ff)
        device_address <= nv_addr; // [R6]
      else if (addr_set)
        device_address <= up_data[7:3]; // [R8]
      if (load_ff)
        temp_ff <= 14'h0000; // [R13]
      else if (conv_done)
        temp_ff <= conv_result; // [R20]
      if (wr_en && ptr_ff == `DCL_PTR_TEMP)
        storage_unlock_bit <= wr_data[`DCL_TEMP_UNLOCK]; // [R26] [R25]
      if (wr_en && ptr_ff == `DCL_PTR_CFG && wr_data[`DCL_CFG_SOFT_RST])
        load_ff <= 1'b1; // [R13]
      if (state_ff == S_CMD && up_valid && up_data == `DCL_CMD_GRST)
        load_ff <= 1'b1; // [R13]
      if (wr_en && ptr_ff == `DCL_PTR_CFG && wr_data[`DCL_CFG_ONE_SHOT] && shutdown_mode)
        os_pend_ff <= 1'b1; // [R22]
      else if (conv_start_ff)
        os_pend_ff <= 1'b0;
      if (!load_ff && !conv_busy && !conv_start_ff && (!shutdown_mode || os_pend_ff))
        conv_start_ff <= 1'b1; // [R20] [R21] [R22]
    end
  end

  // ----------------------------------------
  // operation sequencer
  // ----------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff  <= S_CAL;
      baud_ff   <= `DCL_BAUD_RESET;
      cmd_ff    <= 8'h00;
      ptr_ff    <= 4'h0;
      lo_ff     <= 8'h00;
      sel_ff    <= 1'b0;
      own_ff    <= 1'b0;
      left_ff   <= 6'h00;
      tmr_ff    <= 30'h0;
      aint_ff   <= 30'h0;
      sent_ff   <= 2'h0;
      got_ff    <= 1'b0;
      tx_go_ff  <= 1'b0;
      tx_dat_ff <= 8'h00;
    end else begin
      tx_go_ff <= 1'b0;
      tmr_ff   <= tmr_ff + 30'h1;
      aint_ff  <= aint_ff + 30'h1;
      sent_ff  <= (state_ff == S_SEND || state_ff == S_AGAP || state_ff == S_ANEXT) ? sent_ff : 2'h0;
      case (state_ff)
        S_CAL: begin
          if (cal_valid) begin
            baud_ff  <= cal_baud; // [R2] [R1]
            state_ff <= S_CMD;
          end
        end
        S_CMD: begin
          if (up_valid) begin
            cmd_ff  <= up_data;
            tmr_ff  <= 30'h0;
            aint_ff <= 30'h0;
            if (!up_data[`DCL_FLD_CMD])
              state_ff <= S_PTR; // [R3]
            else if (up_data == `DCL_CMD_AINIT)
              state_ff <= S_AINIT; // [R8]
            else if (up_data == `DCL_CMD_LPOLL) begin
              own_ff   <= nv_last; // [R11] [R12]
              left_ff  <= nv_last ? 6'h00 : 6'h01;
              state_ff <= S_FWD;
            end else
              state_ff <= S_CAL;
          end
        end
        S_PTR: begin
          if (up_valid) begin
            ptr_ff <= up_data[3:0];
            sel_ff <= is_global ? (device_address <= field) : (device_address == field); // [R4] [R14] [R16]
            tmr_ff <= 30'h0;
            if (!is_read)
              state_ff <= S_DLO;
            else if (is_global && device_address <= field) begin
              own_ff   <= 1'b1; // [R17]
              left_ff  <= {(field - device_address), 1'b0};
              state_ff <= S_FWD;
            end else if (!is_global && device_address <= field) begin
              own_ff   <= device_address == field; // [R15] [R27]
              left_ff  <= (device_address == field) ? 6'h00 : 6'h02;
              state_ff <= S_FWD;
            end else
              state_ff <= S_CAL; // [R27]
          end
        end
        S_DLO: begin
          if (up_valid) begin
            lo_ff    <= up_data;
            state_ff <= S_DHI;
          end
        end
        S_DHI: begin
          if (up_valid)
            state_ff <= S_CAL;
        end
        S_FWD: begin
          if (left_ff == 6'h00)
            state_ff <= own_ff ? S_SEND : S_CAL; // [R15] [R19]
          else if (dn_valid) begin
            left_ff <= left_ff - 6'h01; // [R17] [R5]
            tmr_ff  <= 30'h0;
          end else if (tmr_ff >= GRD_CYC)
            state_ff <= S_CAL; // [R18]
        end
        S_SEND: begin
          if (tx_free) begin
            if (sent_ff == (cmd_ff[`DCL_FLD_CMD] ? 2'h1 : 2'h2))
              state_ff <= S_CAL;
            else begin
              tx_go_ff  <= 1'b1; // [R15] [R19]
              tx_dat_ff <= cmd_ff[`DCL_FLD_CMD] ? {device_address, 3'h0} :
                           ((sent_ff == 2'h0) ? rd_val[7:0] : rd_val[15:8]); // [R11]
              sent_ff   <= sent_ff + 2'h1;
            end
          end
        end
        S_AINIT: begin
          if (up_valid) begin
            tmr_ff   <= 30'h0;
            state_ff <= S_AGAP; // [R7] [R8]
          end
        end
        S_AGAP: begin
          if (sent_ff == 2'h0 && tmr_ff >= GAP_CYC) begin
            tx_go_ff  <= 1'b1; // [R8]
            tx_dat_ff <= {device_address, 3'h0};
            sent_ff   <= 2'h1;
          end else if (sent_ff != 2'h0 && tx_free) begin
            sent_ff  <= 2'h0;
            state_ff <= S_ANEXT;
          end
        end
        S_ANEXT: begin
          if (sent_ff == 2'h0) begin
            tx_go_ff  <= 1'b1; // [R8]
            tx_dat_ff <= {device_address + 5'h01, 3'h0};
            sent_ff   <= 2'h1;
          end else if (tx_free) begin
            tmr_ff   <= 30'h0;
            got_ff   <= 1'b0;
            state_ff <= S_AFWD;
          end
        end
        S_AFWD: begin
          if (dn_valid) begin
            got_ff <= 1'b1; // [R8]
            tmr_ff <= 30'h0;
          end else if (tmr_ff >= {GAP_CYC[28:0], 1'b0})
            state_ff <= S_CAL; // [R12]
        end
        default: state_ff <= S_CAL;
      endcase
      if (quiet && aint_ff >= AINIT_CYC)
        state_ff <= S_CAL; // [R10]
    end
  end
endmodule // dcl_link
`default_nettype wire

// ### rtl/dcl_regs.vh
`ifndef DCL_REGS_VH
`define DCL_REGS_VH
// ----------------------------------------
// link words and command codes
// ----------------------------------------
`define DCL_CAL_WORD      8'h55
`define DCL_CAL_FALLS     3'h4
`define DCL_CMD_AINIT     8'h95
`define DCL_CMD_LPOLL     8'h57
`define DCL_CMD_GRST      8'h5d
`define DCL_FLD_GLOBAL    0
`define DCL_FLD_READ      1
`define DCL_FLD_CMD       2
// ----------------------------------------
// register pointers and fields
// ----------------------------------------
`define DCL_PTR_TEMP      4'h0
`define DCL_PTR_CFG       4'h1
`define DCL_PTR_LIM_HI    4'h5
`define DCL_PTR_NV_LO     4'h6
`define DCL_PTR_NV_HI     4'hd
`define DCL_PTR_DIE       4'hf
`define DCL_TEMP_UNLOCK   0
`define DCL_CFG_SOFT_RST  1
`define DCL_CFG_ALERT_LO  3
`define DCL_CFG_ALERT_HI  4
`define DCL_CFG_SHUTDOWN  8
`define DCL_CFG_ONE_SHOT  12
// ----------------------------------------
// reset values
// ----------------------------------------
`define DCL_CFG_RESET     16'ha000
`define DCL_NV_RESET      16'h0000
`define DCL_ADDR_RESET    5'h01
`define DCL_BAUD_RESET    16'h0364
// arbitrary identification value
`define DCL_DIE_ID        16'h0a5c
// ----------------------------------------
// timing
// ----------------------------------------
`define DCL_CLK_NS        10
`define DCL_GAP_MS        7
`define DCL_AINIT_TMO_MS  1000
`define DCL_GRD_TMO_MS    35
`endif

// ### rtl/dcl_rx.v
`default_nettype none
`include "dcl_regs.vh"
module dcl_rx (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        line_in,
  input  wire        cal_en,
  input  wire [15:0] baud_in,
  output reg  [7:0]  data_ff,
  output reg         valid_ff,
  output reg  [15:0] cal_baud_ff,
  output reg         cal_valid_ff
);
  // ----------------------------------------
  // word receiver with baud calibration
  // ----------------------------------------
  localparam [2:0] R_IDLE  = 3'h0;
  localparam [2:0] R_CAL   = 3'h1;
  localparam [2:0] R_START = 3'h2;
  localparam [2:0] R_DATA  = 3'h3;
  localparam [2:0] R_STOP  = 3'h4;

  reg  [2:0]  st_ff;
  reg         prev_ff;
  reg  [18:0] cnt_ff;
  reg  [2:0]  bit_ff;
  wire        fall    = prev_ff & ~line_in;
  wire        bit_end = cnt_ff >= ({3'h0, baud_in} - 19'h1);
  wire [18:0] cal_span = cnt_ff + 19'h1;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff        <= R_IDLE;
      prev_ff      <= 1'b1;
      cnt_ff       <= 19'h0;
      bit_ff       <= 3'h0;
      data_ff      <= 8'h00;
      valid_ff     <= 1'b0;
      cal_baud_ff  <= 16'h0000;
      cal_valid_ff <= 1'b0;
    end else begin
      prev_ff      <= line_in;
      valid_ff     <= 1'b0;
      cal_valid_ff <= 1'b0;
      case (st_ff)
        R_IDLE: begin
          cnt_ff <= 19'h0;
          bit_ff <= 3'h0;
          if (fall)
            st_ff <= cal_en ? R_CAL : R_START;
        end
        R_CAL: begin
          // alternating word: fourth fall after start spans eight bits
          cnt_ff <= cnt_ff + 19'h1;
          if (fall) begin
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == `DCL_CAL_FALLS - 3'h1) begin
              cal_baud_ff  <= cal_span[18:3];
              cal_valid_ff <= 1'b1;
              st_ff        <= R_IDLE;
            end
          end
        end
        R_START: begin
          cnt_ff <= cnt_ff + 19'h1;
          if (cnt_ff >= {4'h0, baud_in[15:1]}) begin
            cnt_ff <= 19'h0;
            st_ff  <= line_in ? R_IDLE : R_DATA;
          end
        end
        R_DATA: begin
          cnt_ff <= cnt_ff + 19'h1;
          if (bit_end) begin
            cnt_ff  <= 19'h0;
            data_ff <= {line_in, data_ff[7:1]};
            bit_ff  <= bit_ff + 3'h1;
            if (bit_ff == 3'h7)
              st_ff <= R_STOP;
          end
        end
        R_STOP: begin
          cnt_ff <= cnt_ff + 19'h1;
          if (bit_end) begin
            valid_ff <= 1'b1;
            st_ff    <= R_IDLE;
          end
        end
        default: st_ff <= R_IDLE;
      endcase
    end
  end
endmodule // dcl_rx
`default_nettype wire

// ### rtl/dcl_tx.v
`default_nettype none
module dcl_tx (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        start,
  input  wire [7:0]  data,
  input  wire [15:0] baud,
  output wire        line_out,
  output wire        busy
);
  // ----------------------------------------
  // word transmitter, lsb first
  // ----------------------------------------
  reg [9:0]  sh_ff;
  reg [3:0]  n_ff;
  reg [15:0] cnt_ff;
  reg        act_ff;

  assign line_out = act_ff ? sh_ff[0] : 1'b1;
  assign busy     = act_ff | start;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sh_ff  <= 10'h3ff;
      n_ff   <= 4'h0;
      cnt_ff <= 16'h0000;
      act_ff <= 1'b0;
    end else if (start && !act_ff) begin
      sh_ff  <= {1'b1, data, 1'b0};
      n_ff   <= 4'h0;
      cnt_ff <= 16'h0000;
      act_ff <= 1'b1;
    end else if (act_ff) begin
      cnt_ff <= cnt_ff + 16'h1;
      if (cnt_ff >= baud - 16'h1) begin
        cnt_ff <= 16'h0000;
        sh_ff  <= {1'b1, sh_ff[9:1]};
        n_ff   <= n_ff + 4'h1;
        if (n_ff == 4'h9)
          act_ff <= 1'b0;
      end
    end
  end
endmodule // dcl_tx
`default_nettype wire

// ### bench/dcl_link_chk.sv
`default_nettype none
module dcl_link_chk #(
  parameter [29:0] GRD_CYC = 30'h7d0
) (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       upstream_pin_in,
  input wire logic       upstream_pin_out,
  input wire logic       upstream_pin_oe,
  input wire logic       downstream_pin_oe,
  input wire logic       conv_busy,
  input wire logic       conv_start_ff,
  input wire logic       shutdown_mode,
  input wire logic       storage_unlock_bit,
  input wire logic [4:0] device_address,
  input wire logic       last_device
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ----
  // idle time toward the host while driving
  // ----
  logic [29:0] idle_cnt_ff;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) idle_cnt_ff <= 30'h0;
    else if (upstream_pin_oe && upstream_pin_out) idle_cnt_ff <= idle_cnt_ff + 30'h1;
    else idle_cnt_ff <= 30'h0;
  end
  chk_start_pulse: assert property (conv_start_ff |=> !conv_start_ff)
    else $error("start pulse too long");
  chk_start_busy: assert property (conv_busy |=> !conv_start_ff)
    else $error("start while converter busy");
  chk_idle_bound: assert property (idle_cnt_ff <= GRD_CYC + 30'h10)
    else $error("link held past silence limit");
  chk_unlock_edge: assert property ($changed(storage_unlock_bit) |-> upstream_pin_in && !upstream_pin_oe)
    else $error("unlock changed outside a write");
  chk_addr_edge: assert property ($changed(device_address) |-> upstream_pin_in)
    else $error("address changed mid word");
  chk_mode_edge: assert property ($changed(shutdown_mode) |-> upstream_pin_in)
    else $error("mode changed mid word");
  chk_last_edge: assert property ($changed(last_device) |-> upstream_pin_in)
    else $error("last flag changed mid word");
  chk_listen_fwd: assert property (!downstream_pin_oe |-> upstream_pin_oe)
    else $error("listening down without forwarding up");
endmodule // dcl_link_chk
bind dcl_link dcl_link_chk #(.GRD_CYC(GRD_CYC)) chk_u (.clock, .sys_rst, .upstream_pin_in, .upstream_pin_out,
  .upstream_pin_oe, .downstream_pin_oe, .conv_busy, .conv_start_ff, .shutdown_mode, .storage_unlock_bit,
  .device_address, .last_device);
`default_nettype wire

// ### bench/dcl_host_model.sv
`default_nettype none
module dcl_host_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clock,
  input  wire logic line_in,
  output var logic  line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line_out = 1'b1;
  // ----
  // word transfer, entered just after an edge
  // ----
  task automatic send(input logic [7:0] b);
    logic [9:0] w;
    w = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out = w[i];
      // stop kept at 3/4 bit so a reply starting at mid stop is seen
      repeat ((i == 9) ? 12 : BIT_CYC) @(posedge clock);
      #1;
    end
  endtask
  task automatic recv(input int lim, output logic [7:0] b);
    int n;
    n = 0;
    b = 8'hxx;
    while (line_in !== 1'b0 && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (line_in !== 1'b0) return;
    repeat (BIT_CYC / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clock);
      #1;
      b[i] = line_in;
    end
    repeat (BIT_CYC) @(posedge clock);
    #1;
    if (line_in !== 1'b1) b = 8'hxx;
  endtask
endmodule // dcl_host_model
`default_nettype wire

// ### bench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [29:0] GRD = 30'h7d0;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic       conv_done = 1'b0;
  logic [13:0] conv_res = 14'h0a0b;
  logic [1:0] conv_alt = 2'h3;
  logic [7:0] b;
  int         conv_left = 0, n_starts = 0, n = 0, cyc = 0, miscompares = 0, n_compared = 0;
  wire        host_out, up_out, up_oe, dn_out, dn_oe, conv_start, shut, unlock, last;
  wire [4:0]  addr;
  wire        up_line = host_out & (up_oe ? up_out : 1'b1);
  wire        dn_line = dn_oe ? dn_out : 1'b1;
  wire        conv_busy = conv_start | (conv_left != 0);
  always #5 clock = ~clock;
  dcl_link #(.GAP_CYC(30'hc8), .AINIT_CYC(30'h4e20), .GRD_CYC(GRD)) dut_u (.clock(clock), .sys_rst(sys_rst),
    .upstream_pin_in(up_line), .upstream_pin_out(up_out), .upstream_pin_oe(up_oe), .downstream_pin_in(dn_line),
    .downstream_pin_out(dn_out), .downstream_pin_oe(dn_oe), .conv_busy(conv_busy), .conv_done(conv_done),
    .conv_result(conv_res), .conv_alert(conv_alt), .conv_start_ff(conv_start), .shutdown_mode(shut),
    .storage_unlock_bit(unlock), .device_address(addr), .last_device(last));
  dcl_host_model host_u (.clock(clock), .line_in(up_line), .line_out(host_out));
  // ----
  // converter model and run limit
  // ----
  always @(posedge clock) begin
    #1;
    conv_done = (conv_left == 1);
    if (conv_left != 0) conv_left = conv_left - 1;
    else if (conv_start) begin
      conv_left = 20;
      n_starts = n_starts + 1;
    end
    cyc = cyc + 1;
    if (cyc == 60000) begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic note(input string s);
    $display("test %s finished", s);
  endtask
  task automatic op(input logic [7:0] cmd, input logic [3:0] ptr, input int k, input logic [15:0] d);
    logic [39:0] w;
    w = {d, 4'ha, ptr, cmd, 8'h55};
    for (int i = 0; i <= k; i++) host_u.send(w[8*i +: 8]);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [3:0] ptr, input logic [15:0] exp);
    logic [7:0] lo, hi;
    op(cmd, ptr, 2, 16'h0);
    host_u.recv(24, lo);
    host_u.recv(24, hi);
    chk({hi, lo}, exp);
    wt(20);
  endtask
  task automatic end_of_test();
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    wt(8);
    sys_rst = 1'b0;
    wt(300);
    chk(16'(addr), 16'h1);
    chk(16'(unlock), 16'h0);
    chk(16'(n_starts != 0), 16'h1);
    note("reset");
    host_u.send(8'h55);
    host_u.send(8'h95);
    host_u.send(8'h18);
    host_u.recv(300, b);
    chk(16'(b), 16'h18);
    wt(900);
    chk(16'(addr), 16'h3);
    chk(16'(last), 16'h1);
    op(8'h57, 4'h0, 1, 16'h0);
    host_u.recv(300, b);
    chk(16'(b), 16'h18);
    wt(20);
    note("init");
    host_u.send(8'h55);
    host_u.send(8'h95);
    wt(20100);
    op(8'h57, 4'h0, 1, 16'h0);
    host_u.recv(300, b);
    chk(16'(b), 16'h18);
    wt(20);
    op(8'h18, 4'h1, 4, 16'h0100);
    wt(20);
    chk(16'(shut), 16'h1);
    n = n_starts;
    op(8'h18, 4'h1, 4, 16'h1100);
    wt(100);
    chk(16'(n_starts - n), 16'h1);
    rd(8'h1a, 4'h1, 16'h0118);
    rd(8'h1a, 4'h0, 16'h282c);
    op(8'h28, 4'h1, 4, 16'h0000);
    wt(20);
    chk(16'(shut), 16'h1);
    note("modes");
    op(8'h18, 4'h6, 4, 16'h1234);
    rd(8'h1a, 4'h6, 16'h0000);
    op(8'h18, 4'h0, 4, 16'h0001);
    wt(20);
    chk(16'(unlock), 16'h1);
    op(8'h18, 4'h6, 4, 16'h1234);
    rd(8'h1a, 4'h6, 16'h1234);
    op(8'h19, 4'h7, 4, 16'h5a5a);
    op(8'h11, 4'h8, 4, 16'h0f0f);
    rd(8'h1a, 4'h7, 16'h5a5a);
    rd(8'h1a, 4'h8, 16'h0000);
    note("storage");
    op(8'h5d, 4'h0, 1, 16'h0);
    wt(40);
    chk(16'(shut), 16'h0);
    rd(8'h1a, 4'h6, 16'h1234);
    rd(8'h1b, 4'h7, 16'h5a5a);
    op(8'h2b, 4'h7, 2, 16'h0);
    wt(100);
    chk(16'(up_oe), 16'h1);
    wt(2000);
    chk(16'(up_oe), 16'h0);
    rd(8'h1a, 4'h1, 16'ha018);
    note("global");
    conv_alt = 2'h2;
    sys_rst = 1'b1;
    wt(8);
    sys_rst = 1'b0;
    wt(40);
    chk(16'(addr), 16'h3);
    chk(16'(unlock), 16'h0);
    rd(8'h1a, 4'h7, 16'h5a5a);
    rd(8'h1a, 4'h1, 16'ha010);
    note("rerun");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
